// [uotg_defines.vh]
// Register offsets, field positions, reset values and timing for the OTG block
`ifndef UOTG_DEFINES_VH
`define UOTG_DEFINES_VH

`define UOTG_OFF_CONTROL   12'h000
`define UOTG_OFF_USBCTL    12'h004
`define UOTG_OFF_FLAGS     12'h008
`define UOTG_OFF_IRQ_EN    12'h00c
`define UOTG_OFF_IRQ_CLR   12'h010
`define UOTG_OFF_LINE      12'h014

`define UOTG_CTL_VBUS_DISCHARGE_ENABLE   0
`define UOTG_CTL_OTG_FEATURE_ENABLE     2
`define UOTG_CTL_DMPD      4
`define UOTG_CTL_DPPD      5
`define UOTG_CTL_DMPU      6
`define UOTG_CTL_DPPU      7
`define UOTG_CTL_MASK      8'hf5

`define UOTG_UCTL_USB_MODULE_ENABLE    0
`define UOTG_UCTL_HOST_MODE_ENABLE   3
`define UOTG_UCTL_MASK     8'h09

`define UOTG_FLG_AVBUS     0
`define UOTG_FLG_BVBUS     2
`define UOTG_FLG_SESSV     3
`define UOTG_FLG_ACTV      4
`define UOTG_FLG_LSTATE    5
`define UOTG_FLG_MSTIMER   6
`define UOTG_FLG_ID        7
`define UOTG_FLG_MASK      8'hfd

`define UOTG_RST_CONTROL   8'h00
`define UOTG_RST_USBCTL    8'h00
`define UOTG_RST_FLAGS     8'h00
`define UOTG_RST_IRQ_EN    8'h00

`define UOTG_LIN_DM        0
`define UOTG_LIN_DP        1
`define UOTG_LIN_ID        2
`define UOTG_LIN_J         4
`define UOTG_LIN_SE0       5

`define UOTG_CLK_HZ        20000000
`define UOTG_MS_TIME_US    1000
`define UOTG_MS_CYCLES     ((`UOTG_CLK_HZ / 1000000) * `UOTG_MS_TIME_US)

`endif

// [uotg_status_pull.v]
// OTG pull resistor control and write-one-to-clear OTG event flags over APB
//
// Functional notes
// - OTG enable set: four software pull bits drive the line resistors.
// - OTG enable clear: pulls follow host enable and module enable.
// - ID pin change sets the ID change flag, bit 7.
// - Free-running 1 ms timer sets the timer flag, bit 6, each expiry.
// - Line state steady 1 ms and differing from last sets bit 5.
// - Activity on D+, D- or VBUS sets the activity flag, bit 4.
// - VBUS crossing A session end threshold sets bit 3.
// - VBUS crossing B session end threshold sets bit 2.
// - VBUS crossing A VBUS valid threshold sets bit 0.
// - Rising and falling threshold crossings both count as events.
// - A flag clears only where a write carries a one.
// - Flag bits 31 to 8 and bit 1 read zero, ignore writes.
// - Flags are set only by hardware; writing zero has no effect.
// - Control bits 7 to 4 enable D+ up, D- up, D+ down, D- down.
`timescale 1ns/1ps
`default_nettype none
`include "uotg_defines.vh"

module uotg_status_pull #(
  parameter MS_CYCLES = `UOTG_MS_CYCLES
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        id_pin,
  input  wire        dplus_rx,
  input  wire        dminus_rx,
  input  wire        vbus_a_sess_end,
  input  wire        vbus_b_sess_end,
  input  wire        vbus_a_valid,
  output reg         dplus_pullup_on,
  output reg         dminus_pullup_on,
  output reg         dplus_pulldown_on,
  output reg         dminus_pulldown_on,
  output wire        vbus_discharge_on,
  output wire        usb_irq
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg  [5:0] sync_a;
  reg  [5:0] sync_b;
  reg  [5:0] sync_d;
  wire [5:0] raw_in = {id_pin, dplus_rx, dminus_rx,
                       vbus_a_sess_end, vbus_b_sess_end, vbus_a_valid};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
    end
  end

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  // The delayed copy holds a real pin sample only from the third edge
  // after reset, so changes are reported from then on; a pin idling
  // high would otherwise look like a change right after reset.
  reg  [2:0] arm;
  wire       primed = arm[2];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_d <= 6'h00;
      arm    <= 3'h0;
    end else begin
      sync_d <= sync_b;
      arm    <= {arm[1:0], 1'b1};
    end
  end

  wire [5:0] chg = primed ? (sync_b ^ sync_d) : 6'h00;
  wire id_s  = sync_b[5];
  wire dp_s  = sync_b[4];
  wire dm_s  = sync_b[3];

  // ----------------------------------------------------------------
  // Millisecond timer and line state filter
  // ----------------------------------------------------------------
  localparam [31:0] MS_LAST = MS_CYCLES - 1;
  reg [31:0] ms_cnt;
  wire       ms_tick = (ms_cnt == MS_LAST);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ms_cnt <= 32'h0000_0000;
    else if (ms_tick)
      ms_cnt <= 32'h0000_0000;
    else
      ms_cnt <= ms_cnt + 32'h0000_0001;
  end

  // Line state: SE0 and J (J taken as D+ high, D- low at full speed)
  wire [1:0] line_now = {~dp_s & ~dm_s, dp_s & ~dm_s};
  reg  [1:0] line_cand;
  reg  [1:0] line_last;
  reg [31:0] stab_cnt;
  reg        lstate_ev;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_cand <= 2'h0;
      line_last <= 2'h0;
      stab_cnt  <= 32'h0000_0000;
      lstate_ev <= 1'b0;
    end else begin
      lstate_ev <= 1'b0;
      if (line_now != line_cand) begin
        line_cand <= line_now;
        stab_cnt  <= 32'h0000_0000;
      end else if (stab_cnt != MS_LAST) begin
        stab_cnt <= stab_cnt + 32'h0000_0001;
      end else if (line_cand != line_last) begin
        line_last <= line_cand;
        lstate_ev <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event vector in flag layout
  // ----------------------------------------------------------------
  wire [7:0] events;
  assign events[`UOTG_FLG_ID]      = chg[5];
  assign events[`UOTG_FLG_MSTIMER] = ms_tick;
  assign events[`UOTG_FLG_LSTATE]  = lstate_ev;
  assign events[`UOTG_FLG_ACTV]    = |chg[4:0];
  assign events[`UOTG_FLG_SESSV]   = chg[2];
  assign events[`UOTG_FLG_BVBUS]   = chg[1];
  assign events[1]                 = 1'b0;
  assign events[`UOTG_FLG_AVBUS]   = chg[0];

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  reg  [7:0] otg_control;
  reg  [7:0] usb_control;
  reg  [7:0] irq_enable;

  wire wr_en = psel & penable & pwrite;
  wire known = (paddr == `UOTG_OFF_CONTROL) | (paddr == `UOTG_OFF_USBCTL) |
               (paddr == `UOTG_OFF_FLAGS)   | (paddr == `UOTG_OFF_IRQ_EN) |
               (paddr == `UOTG_OFF_IRQ_CLR) | (paddr == `UOTG_OFF_LINE);

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~known;

  // Flags and irq clear register share one clear path
  wire clr_hit = wr_en & ((paddr == `UOTG_OFF_FLAGS) |
                          (paddr == `UOTG_OFF_IRQ_CLR));
  wire [7:0] clr_mask = clr_hit ? (pwdata[7:0] & `UOTG_FLG_MASK) : 8'h00;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      otg_control <= `UOTG_RST_CONTROL;
      usb_control <= `UOTG_RST_USBCTL;
      irq_enable  <= `UOTG_RST_IRQ_EN;
    end else begin
      if (wr_en && paddr == `UOTG_OFF_CONTROL)
        otg_control <= pwdata[7:0] & `UOTG_CTL_MASK;
      if (wr_en && paddr == `UOTG_OFF_USBCTL)
        usb_control <= pwdata[7:0] & `UOTG_UCTL_MASK;
      if (wr_en && paddr == `UOTG_OFF_IRQ_EN)
        irq_enable <= pwdata[7:0] & `UOTG_FLG_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Event flags, one hardware-set write-one-to-clear bit per position except bit 1
  // ----------------------------------------------------------------
  localparam [7:0] FLAG_IMPL = `UOTG_FLG_MASK;
  localparam [7:0] FLAG_RST  = `UOTG_RST_FLAGS;

  wire [7:0] otg_event_flags;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_flag
      if (FLAG_IMPL[g]) begin : g_impl
        reg flag;
        // Set wins over clear so an event in the clear cycle survives
        always @(posedge pclk or negedge presetn) begin
          if (!presetn)
            flag <= FLAG_RST[g];
          else
            flag <= (flag & ~clr_mask[g]) | events[g];
        end
        assign otg_event_flags[g] = flag;
      end else begin : g_none
        assign otg_event_flags[g] = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Line status word
  // ----------------------------------------------------------------
  // Live synchronised levels plus the last line state held for 1 ms
  reg [31:0] line_word;

  always @* begin
    line_word                = 32'h0000_0000;
    line_word[`UOTG_LIN_DM]  = dm_s;
    line_word[`UOTG_LIN_DP]  = dp_s;
    line_word[`UOTG_LIN_ID]  = id_s;
    line_word[`UOTG_LIN_J]   = line_last[0];
    line_word[`UOTG_LIN_SE0] = line_last[1];
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // The word is captured at the end of the setup phase, so it comes from
  // a flop and stands for the whole access phase; a flag set on that
  // same edge shows on the next read instead.
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `UOTG_OFF_CONTROL: rd_mux = {24'h000000, otg_control};
      `UOTG_OFF_USBCTL:  rd_mux = {24'h000000, usb_control};
      `UOTG_OFF_FLAGS:   rd_mux = {24'h000000, otg_event_flags};
      `UOTG_OFF_IRQ_EN:  rd_mux = {24'h000000, irq_enable};
      `UOTG_OFF_LINE:    rd_mux = line_word;
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // Zero outside a read keeps the bus quiet between transfers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
    else
      prdata <= 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  assign usb_irq = |(otg_event_flags & irq_enable);

  // ----------------------------------------------------------------
  // Pull resistor selection
  // ----------------------------------------------------------------
  wire otg_en  = otg_control[`UOTG_CTL_OTG_FEATURE_ENABLE];
  wire host_en = usb_control[`UOTG_UCTL_HOST_MODE_ENABLE];
  wire usb_en  = usb_control[`UOTG_UCTL_USB_MODULE_ENABLE];

  // Discharge is only meaningful to a host; software keeps it clear else
  assign vbus_discharge_on = otg_control[`UOTG_CTL_VBUS_DISCHARGE_ENABLE];

  reg next_dplus_pullup;
  reg next_dminus_pullup;
  reg next_dplus_pulldown;
  reg next_dminus_pulldown;

  always @* begin
    if (otg_en) begin
      next_dplus_pullup    = otg_control[`UOTG_CTL_DPPU];
      next_dminus_pullup   = otg_control[`UOTG_CTL_DMPU];
      next_dplus_pulldown  = otg_control[`UOTG_CTL_DPPD];
      next_dminus_pulldown = otg_control[`UOTG_CTL_DMPD];
    end else begin
      // Enabled host pulls both lines down; enabled peripheral attaches on D+
      next_dplus_pullup    = usb_en & ~host_en;
      next_dminus_pullup   = 1'b0;
      next_dplus_pulldown  = usb_en & host_en;
      next_dminus_pulldown = usb_en & host_en;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dplus_pullup_on    <= 1'b0;
      dminus_pullup_on   <= 1'b0;
      dplus_pulldown_on  <= 1'b0;
      dminus_pulldown_on <= 1'b0;
    end else begin
      dplus_pullup_on    <= next_dplus_pullup;
      dminus_pullup_on   <= next_dminus_pullup;
      dplus_pulldown_on  <= next_dplus_pulldown;
      dminus_pulldown_on <= next_dminus_pulldown;
    end
  end

endmodule
`default_nettype wire

// [uotg_sp_assertions.sv]
// Checker for the OTG pull control and event flag block
`timescale 1ns/1ps
`default_nettype none
`include "uotg_defines.vh"
module uotg_sp_assertions (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        usb_irq,
  input wire        vbus_discharge_on,
  input wire        dplus_pullup_on,
  input wire        dminus_pullup_on,
  input wire        dplus_pulldown_on,
  input wire        dminus_pulldown_on
);
  // ----------------------------------------
  // Shadow of the control registers
  // ----------------------------------------
  reg  [7:0] ctl;
  reg  [7:0] uctl;
  wire       wr = psel & penable & pwrite;
  wire       rd = psel & penable & ~pwrite;
  wire [3:0] pul = {dplus_pullup_on, dminus_pullup_on,
                    dplus_pulldown_on, dminus_pulldown_on};
  wire [3:0] aut = !uctl[0] ? 4'h0 : uctl[3] ? 4'h3 : 4'h8;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= 8'h00;
      uctl <= 8'h00;
    end else if (wr && paddr == `UOTG_OFF_CONTROL)
      ctl <= pwdata[7:0] & `UOTG_CTL_MASK;
    else if (wr && paddr == `UOTG_OFF_USBCTL)
      uctl <= pwdata[7:0] & `UOTG_UCTL_MASK;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Pulls are registered, so only judged once the shadow has settled
  property p_otg_pull;
    ctl[2] && $stable(ctl) && $stable(uctl) |-> pul == ctl[7:4];
  endproperty
  a_otg_pull: assert property (p_otg_pull) else $error("otg pulls");
  property p_auto_pull;
    !ctl[2] && $stable(ctl) && $stable(uctl) |-> pul == aut;
  endproperty
  a_auto_pull: assert property (p_auto_pull) else $error("auto pulls");
  property p_disch;
    vbus_discharge_on == ctl[0];
  endproperty
  a_disch: assert property (p_disch) else $error("discharge");
  property p_rsvd;
    rd && paddr == `UOTG_OFF_FLAGS |-> prdata[31:8] == 24'h0 && !prdata[1];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved flag bits");
  property p_unmap;
    psel && penable && paddr > `UOTG_OFF_LINE |-> pslverr && prdata == 0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access");
  property p_err_only;
    pslverr |-> psel && penable;
  endproperty
  a_err_only: assert property (p_err_only) else $error("stray error");
  property p_ready;
    psel && penable |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  // Flags only drop by a software write, so the interrupt can too
  property p_irq_fall;
    $fell(usb_irq) |-> $past(wr);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell");
  property p_idle;
    !psel |-> prdata == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("idle read data");
  c_flag_wr: cover property (wr && paddr == `UOTG_OFF_FLAGS);
  c_irq: cover property (usb_irq);
  c_err: cover property (pslverr);
endmodule
bind uotg_status_pull uotg_sp_assertions i_uotg_sp_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .usb_irq(usb_irq),
  .vbus_discharge_on(vbus_discharge_on), .dplus_pullup_on(dplus_pullup_on),
  .dminus_pullup_on(dminus_pullup_on), .dplus_pulldown_on(dplus_pulldown_on),
  .dminus_pulldown_on(dminus_pulldown_on));
`default_nettype wire

// [uotg_line_model.sv]
// Far side model: ID, D+, D- and VBUS comparator levels
`timescale 1ns/1ps
`default_nettype none
module uotg_line_model (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       tgl,
  input  wire [2:0] sel,
  output reg  [5:0] ln
);
  // Each toggle is a rising or a falling crossing in turn
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ln <= 6'h00;
    else if (tgl)
      ln[sel] <= ~ln[sel];
  end
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the OTG pull control and event flags
`timescale 1ns/1ps
`default_nettype none
`include "uotg_defines.vh"
module tb_top;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tgl = 0, e;
  reg  [11:0] paddr = 0;
  reg  [31:0] pwdata = 0, r, s = 32'h5482011c;
  reg  [7:0]  c, u, x;
  reg  [2:0]  sel = 0;
  wire [31:0] prdata;
  wire [5:0]  ln;
  wire [3:0]  pul;
  wire        pready, pslverr, irq, dis;
  integer     error_cnt = 0, n_tests = 0, cyc = 0, i;
  uotg_status_pull #(.MS_CYCLES(20)) i_uotg_status_pull (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .id_pin(ln[5]), .dplus_rx(ln[4]), .dminus_rx(ln[3]),
    .vbus_a_sess_end(ln[2]), .vbus_b_sess_end(ln[1]), .vbus_a_valid(ln[0]),
    .dplus_pullup_on(pul[3]), .dminus_pullup_on(pul[2]),
    .dplus_pulldown_on(pul[1]), .dminus_pulldown_on(pul[0]),
    .vbus_discharge_on(dis), .usb_irq(irq));
  uotg_line_model i_uotg_line_model (.pclk(pclk), .presetn(presetn),
    .tgl(tgl), .sel(sel), .ln(ln));
  initial forever #25 pclk = ~pclk;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [31:0] lfsr(input [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function [3:0] pexp(input [7:0] cc, input [7:0] uu);
    pexp = cc[2] ? cc[7:4] : !uu[0] ? 4'h0 : uu[3] ? 4'h3 : 4'h8;
  endfunction
  function [7:0] eexp(input [2:0] k);
    eexp = k == 5 ? 8'h80 : k == 2 ? 8'h18 : k == 1 ? 8'h14 :
           k == 0 ? 8'h11 : 8'h10;
  endfunction
  task chk(input [31:0] g, input [31:0] xp);
    begin
      n_tests = n_tests + 1;
      if (g !== xp) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0t got %h exp %h", $time, g, xp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  task kick(input [2:0] k);
    begin
      @(posedge pclk);
      sel <= k;
      tgl <= 1;
      @(posedge pclk);
      tgl <= 0;
      repeat (6) @(posedge pclk);
    end
  endtask
  task conclude;
    begin
      $display("errors %0d checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      conclude;
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    apb(0, `UOTG_OFF_CONTROL, 0);
    chk(r, {24'h0, `UOTG_RST_CONTROL});
    apb(0, `UOTG_OFF_FLAGS, 0);
    chk(r, {24'h0, `UOTG_RST_FLAGS});
    for (i = 0; i < 8; i = i + 1) begin
      s = lfsr(s);
      c = {s[7:3], i[2], s[1:0]} & `UOTG_CTL_MASK &
          (i[1] ? 8'hff : 8'hc0);
      u = {4'h0, i[1], 2'h0, i[0]};
      apb(1, `UOTG_OFF_CONTROL, {s[31:8], c});
      apb(1, `UOTG_OFF_USBCTL, {24'h0, u});
      repeat (2) @(posedge pclk);
      chk({28'h0, pul}, {28'h0, pexp(c, u)});
      chk({31'h0, dis}, {31'h0, c[0]});
      apb(0, `UOTG_OFF_CONTROL, 0);
      chk(r, {24'h0, c});
    end
    apb(1, `UOTG_OFF_CONTROL, 0);
    for (i = 0; i < 12; i = i + 1) begin
      apb(1, `UOTG_OFF_FLAGS, 32'hff);
      kick(i % 6);
      apb(0, `UOTG_OFF_FLAGS, 0);
      chk(r & 32'h9f, eexp(i % 6));
      apb(1, `UOTG_OFF_FLAGS, 0);
      apb(0, `UOTG_OFF_FLAGS, 0);
      chk(r & 32'h9f, eexp(i % 6));
      x = (i % 6 == 3 || i % 6 == 4) ? 8'h10 : eexp(i % 6) & 8'h8f;
      apb(1, `UOTG_OFF_FLAGS, {24'h0, x});
      apb(0, `UOTG_OFF_FLAGS, 0);
      chk(r & 32'h9f, eexp(i % 6) & ~x);
    end
    apb(1, `UOTG_OFF_FLAGS, 32'hff);
    kick(4);
    repeat (25) @(posedge pclk);
    apb(0, `UOTG_OFF_FLAGS, 0);
    chk(r & 32'h60, 32'h60);
    apb(0, `UOTG_OFF_LINE, 0);
    chk(r, 32'h12);
    apb(1, `UOTG_OFF_IRQ_EN, 32'h80);
    apb(1, `UOTG_OFF_FLAGS, 32'hff);
    kick(5);
    chk({31'h0, irq}, 1);
    apb(1, `UOTG_OFF_IRQ_EN, 0);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 0);
    apb(1, `UOTG_OFF_IRQ_EN, 32'h80);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 1);
    apb(1, `UOTG_OFF_IRQ_CLR, 32'h80);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 0);
    apb(0, 12'h020, 0);
    chk({31'h0, e}, 1);
    chk(r, 0);
    conclude;
  end
endmodule
`default_nettype wire
